// >>> src/gdfr_top.sv
// gdfr_top: fault supervision and response of a three-phase gate driver
// assumes comparator and pin levels are asynchronous; fault pin has an outside pullup
`timescale 1ns/1ns
`include "gdfr_defines.svh"
// Operation
// RQ1 - supply undervoltage: report, float, logic off
// RQ2 - charge pump undervoltage unless disabled: report, float
// RQ3 - drain-source overcurrent follows four response modes
// RQ4 - shunt overcurrent follows same four modes
// RQ5 - shunt overcurrent silent when mode off/disabled
// RQ6 - gate stuck past window latches shutdown
// RQ7 - thermal warning reports only when enabled
// RQ8 - thermal shutdown floats drivers, auto recovers
// RQ9 - fault pin only pulls low, pullup outside
// RQ10 - seven-level straps captured once at power-up
// RQ11 - enable, mode, gain captured at power-up
// RQ12 - hardware variant forces four millisecond retry
// RQ13 - latched flags need clear and condition gone
// RQ14 - pin and float from all active sources
module gdfr_top
  import gdfr_pkg::*;
#(
  parameter int RETRY_CYCLES = `GDFR_RETRY_CYCLES
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // analog fault comparators
  input wire gdfr_cond_t condIn,
  // controller pins
  input wire logic clearFaultsCmd,
  input wire logic enablePin,
  // straps
  input wire logic hwVariantPin,
  input wire logic [2:0] gateCurrentSelectPin,
  input wire logic [2:0] drainThresholdSelectPin,
  input wire logic [1:0] modeSelectPin,
  input wire logic [1:0] gainSelectPin,
  // configuration
  input wire logic chargepumpUvDisable,
  input wire logic [1:0] overcurrentResponseMode,
  input wire logic senseOcpDisable,
  input wire logic gateFaultDisable,
  input wire logic thermalWarnReport,
  // fault pin, open drain
  output logic faultOutO,
  output logic faultOutOe,
  // driver and status
  output logic gatesHiZ,
  output logic logicDisabled,
  output logic flagDrainOc,
  output logic flagShuntOc,
  output logic flagGateFault,
  output gdfr_strap_t straps
);

  logic [`GDFR_SYNC_W-1:0] syncVec;
  gdfr_cond_t cond;
  logic clrSync;
  logic enSync;
  logic clrPrev_r;
  logic clrPrev_nxt;
  logic enPrev_r;
  logic enPrev_nxt;
  logic capDone_r;
  logic capDone_nxt;
  logic [1:0] capCnt_r;
  logic [1:0] capCnt_nxt;
  gdfr_strap_t straps_nxt;
  logic [1:0] ocpMode;
  logic cpuvOn;
  logic clearEv;
  logic vdsEv;
  logic senEv;
  logic faultOutOe_nxt;
  logic gatesHiZ_nxt;
  logic logicDisabled_nxt;
  logic flagDrainOc_nxt;
  logic flagShuntOc_nxt;
  logic flagGateFault_nxt;
  gdfr_retry_t rtState_r;
  gdfr_retry_t rtState_nxt;
  logic [`GDFR_CNT_W-1:0] rtCnt_r;
  logic [`GDFR_CNT_W-1:0] rtCnt_nxt;
  logic [`GDFR_CNT_W-1:0] stuckCnt_r;
  logic [`GDFR_CNT_W-1:0] stuckCnt_nxt;

  gdfr_sync u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .asyncIn({condIn, clearFaultsCmd, enablePin, hwVariantPin, gateCurrentSelectPin,
      drainThresholdSelectPin, modeSelectPin, gainSelectPin}),
    .syncOut(syncVec)
  );

  assign cond = syncVec[`GDFR_SYNC_W-1:`GDFR_SYNC_COND_LO];
  assign clrSync = syncVec[`GDFR_SYNC_CLR];
  assign enSync = syncVec[`GDFR_SYNC_EN];

  // straps: synced pins, taken once the sync bank has filled after reset
  always_comb
  begin
    capCnt_nxt = capCnt_r;
    capDone_nxt = capDone_r;
    straps_nxt = straps;
    if (capCnt_r != `GDFR_CAP_EDGES)
      capCnt_nxt = capCnt_r + 2'h1;
    // RQ10 RQ11 one-shot capture
    else if (!capDone_r)
    begin
      capDone_nxt = 1'b1;
      straps_nxt = {syncVec[`GDFR_SYNC_STRAP_HI], enSync, syncVec[`GDFR_SYNC_STRAP_HI-1:0]};
    end
  end

  // clear is a rising edge of the command or the end of an enable low pulse
  always_comb
  begin
    clrPrev_nxt = clrSync;
    enPrev_nxt = enSync;
    clearEv = (clrSync && !clrPrev_r) || (enSync && !enPrev_r);
    // RQ12 hardware variant forces retry
    ocpMode = straps.hwVariant ? `GDFR_OCP_RETRY : overcurrentResponseMode;
    // charge pump check cannot be switched off on the hardware variant
    cpuvOn = cond.chargepumpUndervoltage && (straps.hwVariant || !chargepumpUvDisable);
    // RQ3 mode off ignores drain events
    vdsEv = cond.drainSourceOvercurrent && (ocpMode != `GDFR_OCP_OFF);
    // RQ5 shunt silent when off or disabled
    senEv = cond.shuntOvercurrent && (ocpMode != `GDFR_OCP_OFF) && !senseOcpDisable;
  end

  // flags, retry timer and gate-window counter
  always_comb
  begin
    flagDrainOc_nxt = flagDrainOc;
    flagShuntOc_nxt = flagShuntOc;
    flagGateFault_nxt = flagGateFault;
    rtState_nxt = rtState_r;
    rtCnt_nxt = rtCnt_r;
    stuckCnt_nxt = '0;
    // RQ13 clear only when condition gone
    if (clearEv && ocpMode != `GDFR_OCP_RETRY)
    begin
      if (!cond.drainSourceOvercurrent)
        flagDrainOc_nxt = 1'b0;
      if (!cond.shuntOvercurrent)
        flagShuntOc_nxt = 1'b0;
    end
    if (clearEv && !cond.gateStuck)
      flagGateFault_nxt = 1'b0;
    // RQ3 RQ4 retry expiry releases flags
    case (rtState_r)
      GDFR_RT_IDLE:
      begin
        rtCnt_nxt = '0;
      end
      GDFR_RT_WAIT:
      begin
        if (ocpMode != `GDFR_OCP_RETRY)
          rtState_nxt = GDFR_RT_IDLE;
        else if (rtCnt_r == RETRY_CYCLES[`GDFR_CNT_W-1:0] - 16'h0001)
        begin
          rtState_nxt = GDFR_RT_IDLE;
          flagDrainOc_nxt = 1'b0;
          flagShuntOc_nxt = 1'b0;
        end
        else
          rtCnt_nxt = rtCnt_r + 16'h0001;
      end
      default:
      begin
        rtState_nxt = GDFR_RT_IDLE;
      end
    endcase
    // RQ3 RQ4 events set, winning over clears
    if (vdsEv)
      flagDrainOc_nxt = 1'b1;
    if (senEv)
      flagShuntOc_nxt = 1'b1;
    if ((vdsEv || senEv) && ocpMode == `GDFR_OCP_RETRY && rtState_r == GDFR_RT_IDLE)
    begin
      rtState_nxt = GDFR_RT_WAIT;
      rtCnt_nxt = '0;
    end
    // RQ6 stuck gate timed against window
    if (cond.gateStuck && !gateFaultDisable)
    begin
      if (stuckCnt_r == 16'(`GDFR_GATE_CYCLES - 1))
      begin
        flagGateFault_nxt = 1'b1;
        stuckCnt_nxt = stuckCnt_r;
      end
      else
        stuckCnt_nxt = stuckCnt_r + 16'h0001;
    end
  end

  // pin and driver control from next-state flags and live conditions
  always_comb
  begin
    // RQ1 RQ2 RQ7 RQ8 RQ14 report sources
    faultOutOe_nxt = cond.supplyUndervoltage || cpuvOn || flagDrainOc_nxt ||
      flagShuntOc_nxt || flagGateFault_nxt ||
      (cond.thermalWarning && thermalWarnReport) || cond.thermalShutdown;
    // RQ1 RQ2 RQ8 RQ14 float sources; report-only leaves drivers on
    gatesHiZ_nxt = cond.supplyUndervoltage || cpuvOn || flagGateFault_nxt ||
      cond.thermalShutdown ||
      ((flagDrainOc_nxt || flagShuntOc_nxt) && (ocpMode == `GDFR_OCP_LATCH ||
      ocpMode == `GDFR_OCP_RETRY));
    // RQ1 logic off during undervoltage
    logicDisabled_nxt = cond.supplyUndervoltage;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clrPrev_r <= 1'b0;
      enPrev_r <= 1'b1;
      capDone_r <= 1'b0;
      capCnt_r <= '0;
      straps <= '0;
      flagDrainOc <= 1'b0;
      flagShuntOc <= 1'b0;
      flagGateFault <= 1'b0;
      rtState_r <= GDFR_RT_IDLE;
      rtCnt_r <= '0;
      stuckCnt_r <= '0;
      faultOutOe <= 1'b0;
      faultOutO <= 1'b0;
      gatesHiZ <= 1'b1;
      logicDisabled <= 1'b1;
    end
    else
    begin
      clrPrev_r <= clrPrev_nxt;
      enPrev_r <= enPrev_nxt;
      capDone_r <= capDone_nxt;
      capCnt_r <= capCnt_nxt;
      straps <= straps_nxt;
      flagDrainOc <= flagDrainOc_nxt;
      flagShuntOc <= flagShuntOc_nxt;
      flagGateFault <= flagGateFault_nxt;
      rtState_r <= rtState_nxt;
      rtCnt_r <= rtCnt_nxt;
      stuckCnt_r <= stuckCnt_nxt;
      faultOutOe <= faultOutOe_nxt;
      // RQ9 drive only low
      faultOutO <= 1'b0;
      gatesHiZ <= gatesHiZ_nxt;
      logicDisabled <= logicDisabled_nxt;
    end
  end

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence uvSeen;
    $rose(cond.supplyUndervoltage);
  endsequence

  uv_response_a: assert property (uvSeen |=> faultOutOe && gatesHiZ && logicDisabled) // RQ1
    else $error("undervoltage not reported or floated");
  chargepump_undervoltage_disable_a: assert property (cond.chargepumpUndervoltage && !straps.hwVariant &&
    chargepumpUvDisable && !cond.supplyUndervoltage && !cond.thermalShutdown &&
    !flagDrainOc_nxt && !flagShuntOc_nxt && !flagGateFault_nxt |=> !gatesHiZ) // RQ2
    else $error("disabled charge pump fault floated drivers");
  report_only_a: assert property (ocpMode == `GDFR_OCP_REPORT && vdsEv && !cpuvOn &&
    !cond.supplyUndervoltage && !cond.thermalShutdown && !flagGateFault_nxt
    |=> faultOutOe && !gatesHiZ) // RQ3
    else $error("report-only mode misbehaved");
  latch_hold_a: assert property (flagDrainOc && ocpMode == `GDFR_OCP_LATCH && !clearEv
    |=> flagDrainOc) // RQ13
    else $error("latched flag dropped without clear");
  shunt_off_a: assert property (senseOcpDisable && !flagShuntOc && !clearEv
    |=> !flagShuntOc) // RQ5
    else $error("disabled shunt fault set a flag");
  shunt_latch_a: assert property (senEv && ocpMode == `GDFR_OCP_LATCH
    |=> flagShuntOc && gatesHiZ) // RQ4
    else $error("shunt latch missing");
  gate_window_a: assert property (!gateFaultDisable && cond.gateStuck && !flagGateFault
    |-> ##[1:41] (flagGateFault || !cond.gateStuck || gateFaultDisable)) // RQ6
    else $error("stuck gate not flagged in window");
  warn_report_a: assert property (cond.thermalWarning && thermalWarnReport
    |=> faultOutOe) // RQ7
    else $error("thermal warning not reported");
  thermal_shutdown_float_a: assert property (cond.thermalShutdown |=> gatesHiZ && faultOutOe) // RQ8
    else $error("thermal shutdown not floated");
  pin_low_a: assert property (!faultOutO) // RQ9
    else $error("fault pin driven high");
  strap_hold_a: assert property (capDone_r |=> $stable(straps)) // RQ10
    else $error("straps changed after capture");
  retry_force_a: assert property (straps.hwVariant |-> ocpMode == `GDFR_OCP_RETRY) // RQ12
    else $error("hardware variant not in retry");

endmodule

// >>> src/gdfr_defines.svh
// gdfr_defines.svh: encodings, reset values and timing figures of the fault block
// assumes a 10 MHz sys_clk; included by the package and the design files
`ifndef GDFR_DEFINES_SVH
`define GDFR_DEFINES_SVH

`define GDFR_CLK_PERIOD_NS 100
`define GDFR_RETRY_MS 4
`define GDFR_RETRY_CYCLES (`GDFR_RETRY_MS * 1000000 / `GDFR_CLK_PERIOD_NS)
`define GDFR_GATE_WINDOW_NS 4000
`define GDFR_GATE_CYCLES (`GDFR_GATE_WINDOW_NS / `GDFR_CLK_PERIOD_NS)
`define GDFR_CNT_W 16
`define GDFR_OCP_LATCH 2'h0
`define GDFR_OCP_RETRY 2'h1
`define GDFR_OCP_REPORT 2'h2
`define GDFR_OCP_OFF 2'h3
`define GDFR_SYNC_W 20
// enable idles high, so its stage resets high: no false clear edge after reset
`define GDFR_SYNC_RST 20'h00800
`define GDFR_SYNC_COND_LO 13
`define GDFR_SYNC_CLR 12
`define GDFR_SYNC_EN 11
`define GDFR_SYNC_STRAP_HI 10
`define GDFR_CAP_EDGES 2'h2

`endif

// >>> src/gdfr_pkg.sv
// gdfr_pkg: types shared by the fault supervision block
// assumes gdfr_defines.svh is on the include path
`include "gdfr_defines.svh"
package gdfr_pkg;

  // analog comparator outputs, all asynchronous to sys_clk
  typedef struct packed {
    logic supplyUndervoltage;
    logic chargepumpUndervoltage;
    logic drainSourceOvercurrent;
    logic shuntOvercurrent;
    logic gateStuck;
    logic thermalWarning;
    logic thermalShutdown;
  } gdfr_cond_t;

  // power-up straps, held until the next reset
  typedef struct packed {
    logic hwVariant;
    logic enableLatched;
    logic [2:0] gateCurrentSelect;
    logic [2:0] drainThresholdSelect;
    logic [1:0] modeSelect;
    logic [1:0] gainSelect;
  } gdfr_strap_t;

  typedef enum logic [1:0] {
    GDFR_RT_IDLE = 2'b01,
    GDFR_RT_WAIT = 2'b10
  } gdfr_retry_t;

endpackage

// >>> src/gdfr_sync.sv
// gdfr_sync: two-stage synchroniser bank for pin and comparator levels
// assumes each input is a slow level; no bus coherence between bits
`timescale 1ns/1ns
`include "gdfr_defines.svh"
module gdfr_sync
  import gdfr_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // levels
  input wire logic [`GDFR_SYNC_W-1:0] asyncIn,
  output logic [`GDFR_SYNC_W-1:0] syncOut
);

  logic [`GDFR_SYNC_W-1:0] meta_r;
  logic [`GDFR_SYNC_W-1:0] meta_nxt;
  logic [`GDFR_SYNC_W-1:0] syncOut_nxt;

  always_comb
  begin
    meta_nxt = asyncIn;
    syncOut_nxt = meta_r;
  end

  // first stage is read only by the second
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= `GDFR_SYNC_RST;
      syncOut <= `GDFR_SYNC_RST;
    end
    else
    begin
      meta_r <= meta_nxt;
      syncOut <= syncOut_nxt;
    end
  end

endmodule

// >>> dv/gdfr_ctrl_model.sv
// gdfr_ctrl_model: motor controller beside the fault block
// assumes one sys_clk domain; the bench asks for clears on clearReq
`timescale 1ns/1ns
module gdfr_ctrl_model
(
  // clock
  input wire logic sys_clk,
  // fault pin from the block
  input wire logic faultOutO,
  input wire logic faultOutOe,
  // bench side
  input wire logic clearReq,
  output logic faultLine,
  // clear command to the block
  output logic clearFaultsCmd
);
  assign faultLine = faultOutOe ? faultOutO : 1'b1;

  initial clearFaultsCmd = 1'b0;
  always @(posedge sys_clk)
  begin
    clearFaultsCmd <= clearReq;
  end
endmodule

// >>> dv/tb.sv
// tb: self-checking bench of the fault supervision block
// assumes the controller model resolves the fault wire and issues clears
`timescale 1ns/1ns
module tb
  import gdfr_pkg::*;
;
  logic sys_clk;
  logic rst_n;
  gdfr_cond_t condIn;
  logic clearReq, clearFaultsCmd, enablePin, hwVariantPin;
  logic [2:0] gateCurrentSelectPin, drainThresholdSelectPin;
  logic [1:0] modeSelectPin, gainSelectPin, overcurrentResponseMode;
  logic chargepumpUvDisable, senseOcpDisable, gateFaultDisable, thermalWarnReport;
  logic faultOutO, faultOutOe, faultLine, gatesHiZ, logicDisabled;
  logic flagDrainOc, flagShuntOc, flagGateFault;
  gdfr_strap_t straps;
  logic [5:0] obs;
  int failures, checked, cycles, m;

  // short retry keeps the run brief
  gdfr_top #(.RETRY_CYCLES(20)) u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .condIn(condIn),
    .clearFaultsCmd(clearFaultsCmd), .enablePin(enablePin), .hwVariantPin(hwVariantPin),
    .gateCurrentSelectPin(gateCurrentSelectPin), .drainThresholdSelectPin(drainThresholdSelectPin),
    .modeSelectPin(modeSelectPin), .gainSelectPin(gainSelectPin),
    .chargepumpUvDisable(chargepumpUvDisable), .overcurrentResponseMode(overcurrentResponseMode),
    .senseOcpDisable(senseOcpDisable), .gateFaultDisable(gateFaultDisable),
    .thermalWarnReport(thermalWarnReport), .faultOutO(faultOutO), .faultOutOe(faultOutOe),
    .gatesHiZ(gatesHiZ), .logicDisabled(logicDisabled), .flagDrainOc(flagDrainOc),
    .flagShuntOc(flagShuntOc), .flagGateFault(flagGateFault), .straps(straps));

  gdfr_ctrl_model u_ctrl (.sys_clk(sys_clk), .faultOutO(faultOutO), .faultOutOe(faultOutOe),
    .clearReq(clearReq), .faultLine(faultLine), .clearFaultsCmd(clearFaultsCmd));

  assign obs = {faultLine, gatesHiZ, logicDisabled, flagDrainOc, flagShuntOc, flagGateFault};

  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic end_of_test();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // hangs count as a mismatch
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      failures = failures + 1;
      end_of_test();
    end
  end

  task automatic chk(string nm, logic [11:0] exp, logic [11:0] got);
    checked = checked + 1;
    if (got !== exp)
    begin
      failures = failures + 1;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask

  // outputs: wire, float, logic off, drain, shunt, gate flags
  // sampled mid-cycle where settled; hands back on the next rising edge
  task automatic look(logic [5:0] exp);
    @(negedge sys_clk);
    chk("outputs", {6'h00, exp}, {6'h00, obs});
    @(posedge sys_clk);
  endtask

  // three edges of latency, two spare
  task automatic setc(logic [6:0] v);
    condIn <= v;
    repeat (5) @(posedge sys_clk);
  endtask

  task automatic clr();
    clearReq <= 1'b1;
    repeat (4) @(posedge sys_clk);
    clearReq <= 1'b0;
    repeat (5) @(posedge sys_clk);
  endtask

  task automatic doReset(logic hw);
    rst_n <= 1'b0;
    hwVariantPin <= hw;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
  endtask

  initial
  begin
    failures = 0;
    checked = 0;
    cycles = 0;
    rst_n = 1'b0;
    condIn = 7'h00;
    clearReq = 1'b0;
    enablePin = 1'b1;
    hwVariantPin = 1'b0;
    gateCurrentSelectPin = 3'h5;
    drainThresholdSelectPin = 3'h6;
    modeSelectPin = 2'h2;
    gainSelectPin = 2'h1;
    chargepumpUvDisable = 1'b0;
    overcurrentResponseMode = 2'h0;
    senseOcpDisable = 1'b0;
    gateFaultDisable = 1'b0;
    thermalWarnReport = 1'b1;
    @(posedge sys_clk);
    doReset(1'b0);
    look(6'h20);
    gateCurrentSelectPin <= 3'h2;
    drainThresholdSelectPin <= 3'h1;
    modeSelectPin <= 2'h0;
    gainSelectPin <= 2'h3;
    repeat (4) @(posedge sys_clk);
    chk("straps", 12'h6e9, straps);
    setc(7'h40);
    look(6'h18);
    setc(7'h00);
    look(6'h20);
    setc(7'h20);
    look(6'h10);
    chargepumpUvDisable <= 1'b1;
    repeat (2) @(posedge sys_clk);
    look(6'h20);
    setc(7'h01);
    look(6'h10);
    setc(7'h02);
    look(6'h00);
    thermalWarnReport <= 1'b0;
    repeat (2) @(posedge sys_clk);
    look(6'h20);
    setc(7'h00);
    // every mode for both overcurrent sources
    for (m = 0; m < 8; m++)
    begin
      overcurrentResponseMode <= m[1:0];
      setc(m[2] ? 7'h08 : 7'h10);
      look(m[1:0] == 2'h3 ? 6'h20 : {m[1:0] != 2'h2 ? 2'b01 : 2'b00, 1'b0,
        ~m[2], m[2], 1'b0});
      setc(7'h00);
      if (m[1:0] == 2'h1)
        repeat (25) @(posedge sys_clk);
      else
        clr();
      look(6'h20);
    end
    overcurrentResponseMode <= 2'h0;
    senseOcpDisable <= 1'b1;
    setc(7'h08);
    look(6'h20);
    setc(7'h10);
    clr();
    look(6'h14);
    setc(7'h00);
    look(6'h14);
    enablePin <= 1'b0;
    repeat (4) @(posedge sys_clk);
    enablePin <= 1'b1;
    repeat (6) @(posedge sys_clk);
    look(6'h20);
    setc(7'h04);
    repeat (45) @(posedge sys_clk);
    look(6'h11);
    setc(7'h00);
    clr();
    look(6'h20);
    gateFaultDisable <= 1'b1;
    setc(7'h04);
    repeat (45) @(posedge sys_clk);
    look(6'h20);
    setc(7'h00);
    doReset(1'b1);
    setc(7'h10);
    look(6'h14);
    chk("straps", 12'hd13, straps);
    setc(7'h00);
    repeat (25) @(posedge sys_clk);
    look(6'h20);
    setc(7'h20);
    look(6'h10);
    end_of_test();
  end
endmodule
